// ==== core/bcs_charger.sv ====
// Charge sequencer: phases, timers, suspend, faults and status pins.
//
// Overview of operation
// - Synchronous rectification only while low-side current exceeds 100mA.
// - New charge cycle starts only with temperature in the cold-hot window.
// - Out of cold-to-cutoff window: suspend, stop switching, freeze timers.
// - Suspend holds until temperature is back in cold-hot window, resumes.
// - Battery under deep-discharge threshold at start gives precharge current.
// - Conditioning timer expiry below threshold stops charge, signals fault.
// - In precharge fault a small detection current replaces charge current.
// - Precharge fault clears on reset, battery replacement, charge-enable high or supply loss.
// - Pack-size low gives 4.2 V target, high gives 8.4 V.
// - In voltage regulation, termination current reached ends the charge.
// - Safety timer backs up current-based termination while charging.
// - Recharge level, charge-enable toggle or timer pin event restarts.
// - After reset, charge starts only if battery is below recharge threshold.
// - Timer pin low disables termination and safety timer.
// - Timer pin rising re-enables both and resets the timer count.
// - Timer pin held high disables only the safety timer.
// - Absent adapter supply puts the device in low-power sleep.
// - Charging: charging indicator on; complete: done indicator on only.
// - Suspend, timer fault, overvoltage, sleep: both off.
// - Adapter-present output on past sleep-exit threshold, off in sleep.
// - Charge-enable low allows charge; falling edge clears timers, faults.
// - Overvoltage stops switching, frees status; clears at recharge level.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.svh"
module bcs_charger #(
  parameter int DEB_CYC = `BCS_DEBOUNCE_CYC,
  parameter longint PRECHG_CYC = `BCS_PRECHG_CYC,
  parameter longint SAFETY_CYC = `BCS_SAFETY_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic vcc_above_sleep_exit,
  input wire logic bat_below_deep_discharge,
  input wire logic bat_below_recharge,
  input wire logic bat_overvoltage,
  input wire logic cur_below_term,
  input wire logic lowside_above_sync_min,
  input wire logic temp_above_cold,
  input wire logic temp_below_hot,
  input wire logic temp_below_cutoff,
  input wire logic timer_control_pin_above_en,
  input wire logic timer_control_pin_high,
  input wire logic battery_replaced,
  input wire logic charge_enable_n,
  input wire logic cells_two,
  output logic pwm_enable,
  output logic sync_rect_enable,
  output logic [2:0] current_mode,
  output logic [13:0] vreg_target_mv,
  output logic charging_indicator_out,
  output logic charging_indicator_oe,
  output logic done_indicator_out,
  output logic done_indicator_oe,
  output logic adapter_present_out,
  output logic adapter_present_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning.
  localparam int NF = 11;
  logic [NF-1:0] raw;
  logic [NF-1:0] s1_r;
  logic [NF-1:0] s2_r;
  logic [NF-1:0] flt;
  logic vcc_ok, low_v, below_rch, ovp, i_term, ls_ok;
  logic t_cold_ok, t_hot_ok, t_cut_ok, ttc_en, ttc_hi;
  logic cen_n_s1_r, cen_n_s2_r, cen_n_d_r;
  logic ttc_en_d_r;
  logic rch_d_r;

  assign raw = {vcc_above_sleep_exit, bat_below_deep_discharge,
    bat_below_recharge, bat_overvoltage, cur_below_term,
    lowside_above_sync_min, temp_above_cold, temp_below_hot,
    temp_below_cutoff, timer_control_pin_above_en, timer_control_pin_high};

  // two-stage synchroniser.
  // Only the second stage is read downstream, so a metastable first stage
  // never reaches the filters or the state machine.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  // debounce each decision.
  // Every filter starts low, so a decision that is high out of reset is
  // seen only after the full debounce time.
  for (genvar i = 0; i < NF; i++) begin : g_flt
    bcs_filter #(.CYC(DEB_CYC)) u_flt (
      .clk(clk),
      .nrst(nrst),
      .din(s2_r[i]),
      .dout(flt[i])
    );
  end

  assign {vcc_ok, low_v, below_rch, ovp, i_term, ls_ok, t_cold_ok, t_hot_ok,
    t_cut_ok, ttc_en, ttc_hi} = flt;

  // Charge-enable synchroniser and edge history.
  // The enable history resets to the inhibit level, so releasing reset with
  // the pin low gives one falling edge, which only clears what is clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cen_n_s1_r <= 1'b1;
      cen_n_s2_r <= 1'b1;
      cen_n_d_r <= 1'b1;
      ttc_en_d_r <= 1'b0;
      rch_d_r <= 1'b0;
    end else begin
      cen_n_s1_r <= charge_enable_n;
      cen_n_s2_r <= cen_n_s1_r;
      cen_n_d_r <= cen_n_s2_r;
      ttc_en_d_r <= ttc_en;
      rch_d_r <= below_rch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and timers.
  logic cen_fall, ttc_rise, rch_fall;
  logic temp_init_ok, temp_run_ok;
  logic safety_on;
  logic pre_exp, saf_exp;
  bcs_pkg::bcs_state_e st_r, st_nxt, held_r;
  logic in_charge;
  logic ovp_latch_r;

  // falling edge of active-low charge enable.
  assign cen_fall = cen_n_d_r && !cen_n_s2_r;
  // timer pin rises above its enable threshold.
  assign ttc_rise = ttc_en && !ttc_en_d_r;
  // Battery voltage falling under the recharge level shows as a rising
  // edge of the below-recharge decision.
  assign rch_fall = below_rch && !rch_d_r;
  // initiation window is cold to hot.
  assign temp_init_ok = t_cold_ok && t_hot_ok;
  // running window is cold to cutoff.
  assign temp_run_ok = t_cold_ok && t_cut_ok;
  assign in_charge = (st_r == bcs_pkg::ST_PRECHG) ||
    (st_r == bcs_pkg::ST_FAST) || (st_r == bcs_pkg::ST_VREG);
  // safety timer off when pin low; off when pin held high.
  assign safety_on = ttc_en && !ttc_hi;

  // conditioning timer runs in precharge, frozen in suspend.
  bcs_timer #(.W(40), .LIMIT(40'(PRECHG_CYC))) u_pre (
    .clk(clk),
    .nrst(nrst),
    .clear(cen_fall || st_r == bcs_pkg::ST_IDLE),
    .run(st_r == bcs_pkg::ST_PRECHG),
    .expired(pre_exp)
  );

  // safety timer; cleared on pin rise; frozen in suspend.
  // Suspend is not a charging phase, so the count simply holds there and
  // carries on from the same value once charging resumes.
  bcs_timer #(.W(40), .LIMIT(40'(SAFETY_CYC))) u_saf (
    .clk(clk),
    .nrst(nrst),
    .clear(cen_fall || ttc_rise || st_r == bcs_pkg::ST_IDLE),
    .run(in_charge && safety_on),
    .expired(saf_exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Charge state machine.
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      bcs_pkg::ST_SLEEP: begin
        if (vcc_ok) begin
          st_nxt = bcs_pkg::ST_IDLE;
        end
      end
      bcs_pkg::ST_IDLE: begin
        // start only below recharge threshold; temp window.
        if (!cen_n_s2_r && below_rch && temp_init_ok && !ovp) begin
          st_nxt = low_v ? bcs_pkg::ST_PRECHG : bcs_pkg::ST_FAST;
        end
      end
      bcs_pkg::ST_PRECHG: begin
        if (!low_v) begin
          st_nxt = bcs_pkg::ST_FAST;
        end else if (pre_exp) begin
          st_nxt = bcs_pkg::ST_FAULT;
        end
      end
      bcs_pkg::ST_FAST: begin
        if (!below_rch) begin
          st_nxt = bcs_pkg::ST_VREG;
        end
      end
      bcs_pkg::ST_VREG: begin
        // termination on current; disabled with pin low.
        if (ttc_en && i_term) begin
          st_nxt = bcs_pkg::ST_DONE;
        end
      end
      bcs_pkg::ST_DONE: begin
        // recharge threshold or timer pin event restarts.
        // An edge is the trigger, so a full battery resting above the
        // recharge level does not loop straight back into charging.
        if (rch_fall || ttc_rise) begin
          st_nxt = bcs_pkg::ST_IDLE;
        end else if (ovp_latch_r && below_rch) begin
          // overvoltage ending with the battery already low would
          // otherwise wait for an edge that never comes.
          st_nxt = bcs_pkg::ST_IDLE;
        end
      end
      bcs_pkg::ST_SUSPEND: begin
        // resume in held phase once back in init window.
        if (temp_init_ok) begin
          st_nxt = held_r;
        end
      end
      bcs_pkg::ST_FAULT: begin
        if (battery_replaced) begin
          st_nxt = bcs_pkg::ST_IDLE;
        end
      end
      default: st_nxt = bcs_pkg::ST_IDLE;
    endcase
    // The overrides below are ordered by rising priority: the last one
    // that applies wins, so sleep beats everything and a safety timeout
    // loses to suspend, which must keep the timers frozen.
    // safety timeout ends the charge as a fault.
    if (in_charge && saf_exp) begin
      st_nxt = bcs_pkg::ST_FAULT;
    end
    if (in_charge && !temp_run_ok) begin
      st_nxt = bcs_pkg::ST_SUSPEND;
    end
    // overvoltage stops charging, clears at recharge threshold.
    if (ovp && st_r != bcs_pkg::ST_SLEEP) begin
      st_nxt = bcs_pkg::ST_DONE;
    end
    // charge-enable high inhibits; falling edge clears faults.
    if (cen_n_s2_r || cen_fall) begin
      st_nxt = bcs_pkg::ST_IDLE;
    end
    if (!vcc_ok) begin
      st_nxt = bcs_pkg::ST_SLEEP;
    end
  end

  // State register and the phase held across suspend.
  // The held phase is the last charging phase seen, which is the one that
  // suspend returns to; it starts at fast charge as a harmless default.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= bcs_pkg::ST_SLEEP;
      held_r <= bcs_pkg::ST_FAST;
    end else begin
      st_r <= st_nxt;
      if (in_charge) begin
        held_r <= st_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power stage controls.
  // All of these are registered, so none glitch while the next state is being
  // worked out; those decoded from the state lag it by one clock.

  // overvoltage latch released once battery is at recharge level.
  // A new overvoltage wins over the release in the same cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovp_latch_r <= 1'b0;
    end else if (ovp) begin
      ovp_latch_r <= 1'b1;
    end else if (below_rch) begin
      ovp_latch_r <= 1'b0;
    end
  end

  // Switching, rectification, current mode and target voltage.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_enable <= 1'b0;
      sync_rect_enable <= 1'b0;
      current_mode <= `BCS_CUR_OFF;
      vreg_target_mv <= 14'(`BCS_CELL_ONE_MV);
    end else begin
      // switching stops outside the charging phases.
      pwm_enable <= in_charge && !ovp_latch_r;
      // synchronous mode only above the low-side minimum.
      sync_rect_enable <= in_charge && !ovp_latch_r && ls_ok;
      // pack size selects the regulation target.
      vreg_target_mv <= cells_two ? 14'(`BCS_CELL_TWO_MV) :
        14'(`BCS_CELL_ONE_MV);
      unique case (st_r)
        bcs_pkg::ST_PRECHG: current_mode <= `BCS_CUR_PRECHG;
        bcs_pkg::ST_FAST: current_mode <= `BCS_CUR_FAST;
        bcs_pkg::ST_VREG: current_mode <= `BCS_CUR_VREG;
        bcs_pkg::ST_FAULT: current_mode <= `BCS_CUR_DETECT;
        default: current_mode <= `BCS_CUR_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain status pins; output low always, enable means pulled on.
  // The data bits stay low so that an enabled pin can only sink current;
  // the host or the LEDs see the pin float whenever the enable is low.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      charging_indicator_out <= 1'b0;
      done_indicator_out <= 1'b0;
      adapter_present_out <= 1'b0;
      charging_indicator_oe <= 1'b0;
      done_indicator_oe <= 1'b0;
      adapter_present_oe <= 1'b0;
    end else begin
      // charging shows first, completion shows second.
      charging_indicator_oe <= in_charge && !ovp_latch_r;
      // suspend, fault, overvoltage and sleep release both.
      done_indicator_oe <= (st_r == bcs_pkg::ST_DONE) && !ovp_latch_r;
      // adapter-present on when supply valid, off in sleep.
      adapter_present_oe <= vcc_ok && (st_r != bcs_pkg::ST_SLEEP);
    end
  end
endmodule
`default_nettype wire

// ==== pkg/bcs_regs.svh ====
// Timing counts and fixed encodings of the battery charge sequencer.
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH
`define BCS_CLK_HZ 20000000
`define BCS_DEBOUNCE_US 50
`define BCS_DEBOUNCE_CYC ((`BCS_DEBOUNCE_US * (`BCS_CLK_HZ / 1000000)))
`define BCS_PRECHG_MS 1000
`define BCS_PRECHG_CYC (`BCS_PRECHG_MS * (`BCS_CLK_HZ / 1000))
`define BCS_SAFETY_MS 18000000
`define BCS_SAFETY_CYC (64'd18000000 * 64'd20000)
`define BCS_SYNC_MIN_MA 100
`define BCS_CELL_ONE_MV 4200
`define BCS_CELL_TWO_MV 8400
`define BCS_CUR_OFF 3'h0
`define BCS_CUR_DETECT 3'h1
`define BCS_CUR_PRECHG 3'h2
`define BCS_CUR_FAST 3'h3
`define BCS_CUR_VREG 3'h4
`endif

// ==== pkg/bcs_pkg.sv ====
// Types shared by the battery charge sequencer files.
package bcs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PRECHG = 3'h1,
    ST_FAST = 3'h3,
    ST_VREG = 3'h2,
    ST_DONE = 3'h6,
    ST_SUSPEND = 3'h7,
    ST_FAULT = 3'h5,
    ST_SLEEP = 3'h4
  } bcs_state_e;
endpackage

// ==== core/bcs_filter.sv ====
// Debounce filter for one comparator decision.
`timescale 1ns/1ps
`default_nettype none
module bcs_filter #(
  parameter int CYC = 1000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic [$clog2(CYC+1)-1:0] cnt_r;

  // Output follows the input only after it stands stable for CYC cycles.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_r <= '0;
    end else if (cnt_r == ($clog2(CYC+1))'(CYC - 1)) begin
      cnt_r <= '0;
      dout <= din;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== core/bcs_timer.sv ====
// Freezable timeout counter used for the conditioning and safety timers.
`timescale 1ns/1ps
`default_nettype none
module bcs_timer #(
  parameter int W = 40,
  parameter logic [W-1:0] LIMIT = '1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic run,
  output logic expired
);
  logic [W-1:0] cnt_r;

  // Count while running, hold otherwise, flag once the limit is reached.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      expired <= 1'b0;
    end else if (clear) begin
      cnt_r <= '0;
      expired <= 1'b0;
    end else if (run && !expired) begin
      if (cnt_r >= LIMIT - 1'b1) begin
        expired <= 1'b1;
      end
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== verif/bcs_charger_assertions.sv ====
// Port-level checker for the charge sequencer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.svh"
module bcs_charger_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic vcc_above_sleep_exit,
  input wire logic bat_overvoltage,
  input wire logic temp_below_cutoff,
  input wire logic charge_enable_n,
  input wire logic cells_two,
  input wire logic pwm_enable,
  input wire logic sync_rect_enable,
  input wire logic [2:0] current_mode,
  input wire logic [13:0] vreg_target_mv,
  input wire logic charging_indicator_out,
  input wire logic charging_indicator_oe,
  input wire logic done_indicator_out,
  input wire logic done_indicator_oe,
  input wire logic adapter_present_out,
  input wire logic adapter_present_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  AST_SYNC_RECT: assert property (
    sync_rect_enable |-> pwm_enable) else $error("rectifier without pwm");
  AST_SUSPEND: assert property (
    (!temp_below_cutoff && current_mode != `BCS_CUR_DETECT) [*8]
    |-> !pwm_enable)
    else $error("pwm on while too hot");
  AST_DETECT: assert property (
    current_mode == `BCS_CUR_DETECT
    |-> !charging_indicator_oe && !done_indicator_oe)
    else $error("status on in fault");
  AST_CELLS_TWO: assert property (
    cells_two [*8] |-> vreg_target_mv == 14'h20d0)
    else $error("two-cell target");
  AST_CELLS_ONE: assert property (
    !cells_two [*8] |-> vreg_target_mv == 14'h1068)
    else $error("one-cell target");
  AST_STAT_EXCL: assert property (
    !(charging_indicator_oe && done_indicator_oe))
    else $error("both status on");
  AST_CHG_MODE: assert property (
    charging_indicator_oe
    |-> pwm_enable && current_mode inside {3'h2, 3'h3, 3'h4})
    else $error("charging status without charge");
  AST_OD_LOW: assert property (
    !charging_indicator_out && !done_indicator_out && !adapter_present_out)
    else $error("open-drain data high");
  AST_SLEEP: assert property (
    !vcc_above_sleep_exit [*8] |-> !adapter_present_oe && !pwm_enable)
    else $error("active while asleep");
  AST_CE_OFF: assert property (
    charge_enable_n [*8] |-> !pwm_enable) else $error("pwm while inhibited");
  AST_OVP: assert property (
    bat_overvoltage [*8] |-> !pwm_enable && !charging_indicator_oe)
    else $error("charging in overvoltage");
  // Main scenarios reached.
  COV_CHG: cover property (charging_indicator_oe);
  COV_DONE: cover property (done_indicator_oe);
  COV_FAULT: cover property (current_mode == `BCS_CUR_DETECT);
endmodule
bind bcs_charger bcs_charger_checker i_chk (.*);
`default_nettype wire

// ==== verif/bcs_battery_model.sv ====
// Behavioural battery pack whose level follows the charger output.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.svh"
module bcs_battery_model (
  input wire logic clk,
  input wire logic pwm_enable,
  input wire logic [2:0] current_mode,
  input wire logic stuck,
  input wire logic load,
  input wire logic [7:0] load_lvl,
  output logic bat_below_deep_discharge,
  output logic bat_below_recharge,
  output logic cur_below_term
);
  logic [7:0] lvl_r;
  // Charging raises the level unless the pack is stuck; bench may load it.
  always_ff @(posedge clk) begin
    if (load) begin
      lvl_r <= load_lvl;
    end else if (pwm_enable && !stuck && lvl_r < 8'd100) begin
      lvl_r <= lvl_r + 8'd1;
    end
  end
  // Comparator decisions seen by the charger.
  assign bat_below_deep_discharge = lvl_r < 8'd20;
  assign bat_below_recharge = lvl_r < 8'd90;
  assign cur_below_term = current_mode == `BCS_CUR_VREG && lvl_r >= 8'd100;
endmodule
`default_nettype wire

// ==== verif/battery_charge_sequencer_tb_top.sv ====
// Self-checking bench for the charge sequencer with a battery model.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.svh"
module battery_charge_sequencer_tb_top;
  logic clk = 1'b0, nrst = 1'b0, vcc_above_sleep_exit, bat_overvoltage;
  logic lowside_above_sync_min, temp_above_cold, temp_below_hot;
  logic temp_below_cutoff, timer_control_pin_above_en, timer_control_pin_high;
  logic battery_replaced, charge_enable_n, cells_two, stuck, load;
  logic bat_below_deep_discharge, bat_below_recharge, cur_below_term;
  logic pwm_enable, sync_rect_enable, charging_indicator_out;
  logic charging_indicator_oe, done_indicator_out, done_indicator_oe;
  logic adapter_present_out, adapter_present_oe;
  logic [7:0] load_lvl;
  logic [2:0] current_mode;
  logic [13:0] vreg_target_mv;
  logic [31:0] seed = 32'h17c093a4;
  int num_errors = 0, num_checks = 0;
  bcs_charger #(.DEB_CYC(2), .PRECHG_CYC(50), .SAFETY_CYC(200)) i_dut (.*);
  bcs_battery_model i_bat (.*);
  // Clock of 50 ns period.
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // Next value of the xorshift generator.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Expected regulation target for the pack size.
  function automatic logic [13:0] exp_vreg(input logic two);
    return two ? 14'h20d0 : 14'h1068;
  endfunction
  task automatic chk(input string what, input logic [15:0] e,
    input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic stat(input logic [1:0] e);
    chk("status", {14'h0, e},
      {14'h0, charging_indicator_oe, done_indicator_oe});
  endtask
  // Waits a bounded time for a charge mode, then compares it.
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 400 && current_mode !== m; i++) cyc(1);
    chk("current_mode", {13'h0, m}, {13'h0, current_mode});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog against a hung sequence.
  initial begin
    #(50 * 6000);
    num_errors++;
    results;
  end
  initial begin
    {vcc_above_sleep_exit, bat_overvoltage, battery_replaced} = 3'h0;
    {charge_enable_n, timer_control_pin_high, stuck, load_lvl} = 11'h0;
    {temp_above_cold, temp_below_hot, temp_below_cutoff, load} = 4'hf;
    {lowside_above_sync_min, timer_control_pin_above_en} = 2'h3;
    seed = xs(seed);
    cells_two = seed[0];
    cyc(2);
    nrst = 1'b1;
    cyc(12);
    chk("adapter_present_oe", 16'h0, {15'h0, adapter_present_oe});
    vcc_above_sleep_exit = 1'b1;
    load = 1'b0;
    timer_control_pin_high = 1'b1;
    cyc(12);
    chk("adapter_present_oe", 16'h1, {15'h0, adapter_present_oe});
    $display("test sleep exit done");
    wait_mode(`BCS_CUR_PRECHG);
    stat(2'b10);
    wait_mode(`BCS_CUR_FAST);
    // Hold the pack level so fast charge lasts through the next tests.
    stuck = 1'b1;
    lowside_above_sync_min = 1'b0;
    cyc(8);
    chk("sync_rect_enable low", 16'h0, {15'h0, sync_rect_enable});
    chk("pwm_enable low current", 16'h1, {15'h0, pwm_enable});
    lowside_above_sync_min = 1'b1;
    cyc(8);
    chk("sync_rect_enable high", 16'h1, {15'h0, sync_rect_enable});
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      temp_below_cutoff = 1'b0;
      cyc(1);
      temp_below_cutoff = 1'b1;
      cyc(3 + seed[2:0]);
      chk("pwm_enable glitch", 16'h1, {15'h0, pwm_enable});
    end
    {temp_below_cutoff, temp_below_hot} = 2'h0;
    cyc(10);
    chk("pwm_enable suspend", 16'h0, {15'h0, pwm_enable});
    stat(2'b00);
    temp_below_cutoff = 1'b1;
    cyc(10);
    chk("pwm_enable hot", 16'h0, {15'h0, pwm_enable});
    {temp_below_hot, stuck} = 2'h2;
    wait_mode(`BCS_CUR_FAST);
    wait_mode(`BCS_CUR_VREG);
    chk("vreg_target_mv", {2'h0, exp_vreg(cells_two)},
      {2'h0, vreg_target_mv});
    for (int i = 0; i < 200 && done_indicator_oe !== 1'b1; i++) cyc(1);
    stat(2'b01);
    $display("test full charge done");
    {load, load_lvl, stuck, timer_control_pin_high} = {1'b1, 8'd50, 2'h2};
    cyc(1);
    load = 1'b0;
    wait_mode(`BCS_CUR_FAST);
    wait_mode(`BCS_CUR_DETECT);
    stat(2'b00);
    charge_enable_n = 1'b1;
    cyc(10);
    chk("pwm_enable inhibit", 16'h0, {15'h0, pwm_enable});
    {load, load_lvl} = {1'b1, 8'd0};
    cyc(1);
    load = 1'b0;
    // Let the deep-discharge decision settle before enabling again.
    cyc(8);
    charge_enable_n = 1'b0;
    wait_mode(`BCS_CUR_PRECHG);
    wait_mode(`BCS_CUR_DETECT);
    cyc(20);
    chk("current_mode held", {13'h0, `BCS_CUR_DETECT},
      {13'h0, current_mode});
    {stuck, battery_replaced} = 2'h1;
    cyc(3);
    battery_replaced = 1'b0;
    wait_mode(`BCS_CUR_PRECHG);
    $display("test faults done");
    bat_overvoltage = 1'b1;
    cyc(10);
    chk("pwm_enable ovp", 16'h0, {15'h0, pwm_enable});
    stat(2'b00);
    {bat_overvoltage, vcc_above_sleep_exit} = 2'h0;
    cyc(12);
    chk("adapter_present_oe", 16'h0, {15'h0, adapter_present_oe});
    stat(2'b00);
    $display("test overvoltage and sleep done");
    results;
  end
endmodule
`default_nettype wire
